// ===== inc/psram_link_pkg.sv
// Constants and types shared by the pseudo-static DRAM link port
package psram_link_pkg;

  // ==========================================================
  // Link sequencing states, Gray coded along idle-cmd-lat-data
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_CMD  = 2'b01,
    ST_LAT  = 2'b11,
    ST_DATA = 2'b10
  } link_state_t;

  // ==========================================================
  // Widths
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int CA_W = 48;
  localparam int CNT_W = 5;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_W = DATA_W + 2;

  // ==========================================================
  // Bit positions inside the synchronised pin vector
  localparam int IN_CLK_T = 0;
  localparam int IN_CLK_C = 1;
  localparam int IN_SEL = 2;
  localparam int IN_DIFF = 3;
  localparam int IN_STRB = 4;
  localparam int IN_DQ = 6;
  localparam int IN_W = 22;

  // Idle pin levels: clock low, complement high, select high
  localparam logic [IN_W-1:0] IN_RESET = 22'h000006;

  // ==========================================================
  // Sequencing counts, in link clock edges
  localparam logic [CNT_W-1:0] CA_LAST = 5'h05;
  localparam logic [CNT_W-1:0] LAT_EDGES = 5'h0c;
  localparam logic [CNT_W-1:0] LAT_EDGES_X2 = 5'h18;

  // ==========================================================
  // Values after reset
  localparam logic [CNT_W-1:0] CNT_RESET = 5'h00;
  localparam logic [1:0] STRB_RESET = 2'h0;
  localparam logic [DATA_W-1:0] DQ_RESET = 16'h0000;
  localparam logic [CA_W-1:0] CA_RESET = 48'h000000000000;

endpackage

// ===== logic/link_fifo.sv
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module link_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_ff;
  logic [AW-1:0] rptr_ff;
  logic [AW:0] count_ff;

  // ==========================================================
  // Handshake decode
  wire do_push = in_valid & in_ready;
  wire do_pop = out_valid & out_ready;
  assign in_ready = (count_ff != FULL_CNT);
  assign out_valid = (count_ff != '0);
  assign out_data = mem[rptr_ff];

  // Storage; no reset needed, guarded by the count
  always_ff @(posedge sys_clk)
  begin
    if (do_push)
    begin
      mem[wptr_ff] <= in_data;
    end
  end

  // Pointers wrap naturally; depth must be a power of two
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      count_ff <= '0;
    end
    else
    begin
      if (do_push)
        wptr_ff <= wptr_ff + 1'b1;
      if (do_pop)
        rptr_ff <= rptr_ff + 1'b1;
      if (do_push && !do_pop)
        count_ff <= count_ff + 1'b1;
      else if (do_pop && !do_push)
        count_ff <= count_ff - 1'b1;
    end
  end
endmodule

// ===== logic/psram_link_port.sv
// Device-side slave port of a DDR x16 pseudo-static DRAM link
`timescale 1ns/10ps
module psram_link_port (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Link clock and select
  input wire logic link_clk,
  input wire logic clock_complement,
  input wire logic diff_mode,
  input wire logic sel_n,
  // Data lines
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  output logic dq_oe,
  // Strobe and mask lines
  input wire logic [1:0] strobe_mask_lines_in,
  output logic [1:0] strobe_mask_lines_out,
  output logic [1:0] strobe_mask_lines_oe,
  // Command side
  input wire logic refresh_req,
  output logic [47:0] ca_word,
  output logic ca_valid,
  output logic txn_active,
  // Read data supply
  input wire logic [15:0] rd_word,
  output logic rd_take,
  // Write data drain
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [15:0] wr_data,
  output logic [1:0] wr_be,
  output logic wr_overflow
);

  // ==========================================================
  // Pin synchroniser: three stages, a bit moves once 2 and 3 agree
  logic [psram_link_pkg::IN_W-1:0] s1_ff;
  logic [psram_link_pkg::IN_W-1:0] s2_ff;
  logic [psram_link_pkg::IN_W-1:0] s3_ff;
  logic [psram_link_pkg::IN_W-1:0] filt_ff;
  wire [psram_link_pkg::IN_W-1:0] raw_in = {dq_in, strobe_mask_lines_in,
    diff_mode, sel_n, clock_complement, link_clk};
  wire [psram_link_pkg::IN_W-1:0] nxt_filt = (s2_ff & s3_ff) |
    (filt_ff & (s2_ff ^ s3_ff));

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_ff <= psram_link_pkg::IN_RESET;
      s2_ff <= psram_link_pkg::IN_RESET;
      s3_ff <= psram_link_pkg::IN_RESET;
      filt_ff <= psram_link_pkg::IN_RESET;
    end
    else
    begin
      s1_ff <= raw_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      filt_ff <= nxt_filt;
    end
  end

  // Filtered pin views
  wire clk_t = filt_ff[psram_link_pkg::IN_CLK_T];
  wire clk_c = filt_ff[psram_link_pkg::IN_CLK_C];
  wire sel_f = filt_ff[psram_link_pkg::IN_SEL];
  wire diff_f = filt_ff[psram_link_pkg::IN_DIFF];
  wire [1:0] strb_f = filt_ff[psram_link_pkg::IN_STRB +: 2];
  wire [15:0] dq_f = filt_ff[psram_link_pkg::IN_DQ +: 16];

  // ==========================================================
  // Clock level and edge finder
  logic clk_lvl_ff;
  logic sel_prev_ff;
  // Differential level only moves on a crossing, so equal levels hold
  wire clk_lvl = diff_f ? ((clk_t != clk_c) ? clk_t : clk_lvl_ff)
                        : clk_t;
  // Edges, not cycles, advance the link; a stopped clock just waits
  wire link_edge = clk_lvl ^ clk_lvl_ff;
  wire sel_fall = sel_prev_ff & ~sel_f;
  wire sel_rise = ~sel_prev_ff & sel_f;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      clk_lvl_ff <= 1'b0;
      sel_prev_ff <= 1'b1;
    end
    else
    begin
      clk_lvl_ff <= clk_lvl;
      sel_prev_ff <= sel_f;
    end
  end

  // ==========================================================
  // Transaction sequencer
  psram_link_pkg::link_state_t state_ff;
  psram_link_pkg::link_state_t nxt_state;
  logic [psram_link_pkg::CNT_W-1:0] cnt_ff;
  logic [psram_link_pkg::CNT_W-1:0] nxt_cnt;
  logic [psram_link_pkg::CNT_W-1:0] lat_target_ff;
  logic [psram_link_pkg::CNT_W-1:0] nxt_target;
  logic is_read_ff;
  logic nxt_read;
  logic extra_ff;
  logic nxt_extra;
  logic [39:0] ca_sr_ff;

  // Event qualifiers; a select edge always wins over a clock edge
  wire quiet = ~sel_rise & ~sel_fall;
  wire step = link_edge & quiet;
  wire cmd_edge = step & (state_ff == psram_link_pkg::ST_CMD);
  wire ca_done = cmd_edge & (cnt_ff == psram_link_pkg::CA_LAST);
  wire lat_edge = step & (state_ff == psram_link_pkg::ST_LAT);
  wire data_edge = step & (state_ff == psram_link_pkg::ST_DATA);
  wire rd_edge = data_edge & is_read_ff;
  wire wr_edge = data_edge & ~is_read_ff;
  // Busy drain side or a refresh request costs the host extra latency
  wire want_extra = refresh_req | wr_valid;
  wire [psram_link_pkg::CNT_W-1:0] lat_pick = extra_ff ?
    psram_link_pkg::LAT_EDGES_X2 : psram_link_pkg::LAT_EDGES;
  wire lat_last = (cnt_ff == lat_target_ff - 5'h01);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_read = is_read_ff;
    nxt_extra = extra_ff;
    nxt_target = lat_target_ff;
    if (sel_rise)
      nxt_state = psram_link_pkg::ST_IDLE;
    else if (sel_fall)
    begin
      nxt_state = psram_link_pkg::ST_CMD;
      nxt_cnt = psram_link_pkg::CNT_RESET;
      nxt_extra = want_extra;
    end
    else if (link_edge)
    begin
      unique case (state_ff)
        psram_link_pkg::ST_IDLE:
          nxt_state = psram_link_pkg::ST_IDLE;
        psram_link_pkg::ST_CMD:
          if (ca_done)
          begin
            nxt_state = psram_link_pkg::ST_LAT;
            nxt_cnt = psram_link_pkg::CNT_RESET;
            nxt_read = ca_sr_ff[39];
            nxt_target = lat_pick;
          end
          else
            nxt_cnt = cnt_ff + 5'h01;
        psram_link_pkg::ST_LAT:
          if (lat_last)
            nxt_state = psram_link_pkg::ST_DATA;
          else
            nxt_cnt = cnt_ff + 5'h01;
        psram_link_pkg::ST_DATA:
          nxt_state = psram_link_pkg::ST_DATA;
      endcase
    end
  end

  // Async reset returns the port to standby with lines released
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= psram_link_pkg::ST_IDLE;
      cnt_ff <= psram_link_pkg::CNT_RESET;
      lat_target_ff <= psram_link_pkg::LAT_EDGES;
      is_read_ff <= 1'b0;
      extra_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      lat_target_ff <= nxt_target;
      is_read_ff <= nxt_read;
      extra_ff <= nxt_extra;
    end
  end

  // ==========================================================
  // Command/address capture from the low byte only
  logic [47:0] ca_word_ff;
  logic ca_valid_ff;
  wire [39:0] nxt_ca_sr = cmd_edge ? {ca_sr_ff[31:0], dq_f[7:0]}
                                   : ca_sr_ff;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ca_sr_ff <= 40'h0000000000;
      ca_word_ff <= psram_link_pkg::CA_RESET;
      ca_valid_ff <= 1'b0;
    end
    else
    begin
      ca_sr_ff <= nxt_ca_sr;
      ca_valid_ff <= ca_done;
      if (ca_done)
        ca_word_ff <= {ca_sr_ff, dq_f[7:0]};
    end
  end

  // ==========================================================
  // Line drivers: strobe as latency flag then read strobe
  logic [15:0] dq_out_ff;
  logic dq_oe_ff;
  logic [1:0] strb_out_ff;
  logic [1:0] strb_oe_ff;
  logic rd_take_ff;
  wire nxt_in_cmd = (nxt_state == psram_link_pkg::ST_CMD);
  wire nxt_in_lat = (nxt_state == psram_link_pkg::ST_LAT);
  wire nxt_in_data = (nxt_state == psram_link_pkg::ST_DATA);
  wire nxt_dq_oe = nxt_in_data & nxt_read;
  wire nxt_strb_drv = nxt_in_cmd |
    ((nxt_in_lat | nxt_in_data) & nxt_read);
  // Both bits always share one value
  wire [1:0] nxt_strb = nxt_in_cmd ? {2{nxt_extra}} :
                        rd_edge ? ~strb_out_ff :
                        nxt_in_lat ? psram_link_pkg::STRB_RESET :
                        strb_out_ff;
  // New word and strobe flip leave on the same edge
  wire [15:0] nxt_dq_out = rd_edge ? rd_word : dq_out_ff;

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dq_out_ff <= psram_link_pkg::DQ_RESET;
      dq_oe_ff <= 1'b0;
      strb_out_ff <= psram_link_pkg::STRB_RESET;
      strb_oe_ff <= psram_link_pkg::STRB_RESET;
      rd_take_ff <= 1'b0;
    end
    else
    begin
      dq_out_ff <= nxt_dq_out;
      dq_oe_ff <= nxt_dq_oe;
      strb_out_ff <= nxt_strb;
      strb_oe_ff <= {2{nxt_strb_drv}};
      rd_take_ff <= rd_edge;
    end
  end

  // ==========================================================
  // Write path: mask bits turn into byte enables
  logic wr_overflow_ff;
  logic fifo_in_ready;
  logic [psram_link_pkg::FIFO_W-1:0] fifo_out;
  // A fully masked word changes nothing, so it is not queued
  wire mask_all = &strb_f;
  wire push_req = wr_edge & ~mask_all;
  wire push = push_req & fifo_in_ready;
  // The host cannot be stalled mid-burst; a full queue drops the word
  wire nxt_overflow = push_req & ~fifo_in_ready;
  wire [psram_link_pkg::FIFO_W-1:0] push_data =
    {~strb_f, dq_f};

  link_fifo #(
    .WIDTH(psram_link_pkg::FIFO_W),
    .DEPTH(psram_link_pkg::FIFO_DEPTH)
  ) u_wr_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(push_data),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(fifo_out)
  );

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      wr_overflow_ff <= 1'b0;
    else
      wr_overflow_ff <= nxt_overflow;
  end

  // ==========================================================
  // Output mapping
  assign dq_out = dq_out_ff;
  assign dq_oe = dq_oe_ff;
  assign strobe_mask_lines_out = strb_out_ff;
  assign strobe_mask_lines_oe = strb_oe_ff;
  assign ca_word = ca_word_ff;
  assign ca_valid = ca_valid_ff;
  assign txn_active = (state_ff != psram_link_pkg::ST_IDLE);
  assign rd_take = rd_take_ff;
  assign wr_data = fifo_out[15:0];
  assign wr_be = fifo_out[17:16];
  assign wr_overflow = wr_overflow_ff;

  // ==========================================================
  // Assertions
  start_cmd_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_ff == psram_link_pkg::ST_IDLE && sel_fall) |=>
    (state_ff == psram_link_pkg::ST_CMD && cnt_ff == 5'h00))
    else $error("select fall did not start command phase");
  end_idle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    sel_rise |=> (state_ff == psram_link_pkg::ST_IDLE && !dq_oe &&
    strobe_mask_lines_oe == 2'b00))
    else $error("select rise did not end transaction");
  lat_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_ff == psram_link_pkg::ST_CMD) |->
    (strobe_mask_lines_oe == 2'b11 &&
    strobe_mask_lines_out == {2{extra_ff}}))
    else $error("latency flag not driven in command phase");
  lat_len_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    lat_edge |=> ((state_ff == psram_link_pkg::ST_DATA) ==
    ($past(cnt_ff) == $past(lat_target_ff) - 5'h01)))
    else $error("latency length wrong");
  rd_toggle_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_edge |=> (strobe_mask_lines_out != $past(strobe_mask_lines_out)
    && dq_out == $past(rd_word) && rd_take))
    else $error("read strobe not aligned with data");
  reset_hiz_a: assert property (@(posedge sys_clk)
    !rst_n |-> (!dq_oe && strobe_mask_lines_oe == 2'b00))
    else $error("lines driven during reset");
  mask_skip_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (wr_edge && strb_f == 2'b11) |-> !push)
    else $error("fully masked word was queued");
  ca_low_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ca_valid |-> (ca_word[7:0] == $past(dq_f[7:0]) &&
    $past(state_ff) == psram_link_pkg::ST_CMD))
    else $error("command byte not from low lines");
  hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (state_ff == psram_link_pkg::ST_LAT && !link_edge && quiet) |=>
    ($stable(cnt_ff) && state_ff == psram_link_pkg::ST_LAT))
    else $error("latency advanced without a clock edge");
  same_bits_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (strobe_mask_lines_oe != 2'b00) |->
    (strobe_mask_lines_out[0] == strobe_mask_lines_out[1]))
    else $error("strobe bits differ");

  // Main scenarios
  read_cov_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    rd_edge);
  write_cov_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    push);
  extra_cov_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    ca_done && extra_ff);
  full_cov_c: cover property (@(posedge sys_clk) disable iff (!rst_n)
    nxt_overflow);
endmodule

// ===== dv/host_link_model.sv
// Host-side link controller model: select, link clock and write data
`timescale 1ns/10ps
module host_link_model (
  // Clock
  input wire logic sys_clk,
  // Link pins toward the device
  output logic link_clk,
  output logic clock_complement,
  input wire logic diff_mode,
  output logic sel_n,
  output logic [15:0] dq_host,
  output logic [1:0] strb_host,
  // Strobe level as seen on the wire
  input wire logic [1:0] strb_wire
);
  logic junk_ff;
  int stall;

  // ==========================================================
  // Complement tracks the true clock only in differential mode
  assign clock_complement = diff_mode ? ~link_clk : junk_ff;

  // Garbage on the complement proves single-ended mode ignores it
  always @(negedge sys_clk) junk_ff <= ~junk_ff;

  initial
  begin
    link_clk = 1'b0;
    sel_n = 1'b1;
    dq_host = 16'h0000;
    strb_host = 2'h0;
    junk_ff = 1'b0;
    stall = 0;
  end

  // ==========================================================
  // One link edge, data centred; clock stops between edges
  task automatic step(input logic [15:0] d, input logic [1:0] m);
    dq_host = d;
    strb_host = m;
    repeat (2) @(negedge sys_clk);
    link_clk = ~link_clk;
    repeat (2 + stall) @(negedge sys_clk);
  endtask

  // ==========================================================
  // Whole transaction; released lines show the inverse of the last value
  task automatic run(input logic [47:0] ca, input logic [7:0] junk,
    input int n, input logic [17:0] words [32], input int slow,
    output logic [1:0] lat);
    int lat_n;
    stall = slow;
    @(negedge sys_clk);
    // Select falls only while the clock idles low
    sel_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    // A real host counts its wait from the latency flag
    lat = strb_wire;
    lat_n = (strb_wire == 2'h3) ? int'(psram_link_pkg::LAT_EDGES_X2)
      : int'(psram_link_pkg::LAT_EDGES);
    // Upper lines driven to defined junk in the command phase
    for (int i = 5; i >= 0; i--)
    begin
      step({junk + 8'(i), ca[8*i +: 8]}, ~strb_host);
    end
    for (int i = 0; i < lat_n; i++)
    begin
      step(~dq_host, ~strb_host);
    end
    // Write words carry their byte masks on the strobe lines
    for (int i = 0; i < n; i++)
    begin
      if (ca[47])
        step(~dq_host, ~strb_host);
      else
        step(words[i][15:0], words[i][17:16]);
    end
    // Select rises with the clock back at idle
    sel_n = 1'b1;
    dq_host = ~dq_host;
    strb_host = ~strb_host;
    repeat (6) @(negedge sys_clk);
  endtask
endmodule

// ===== dv/tb.sv
// Self-checking bench for the pseudo-static DRAM link port
`timescale 1ns/10ps
module tb;
  logic sys_clk, rst_n, link_clk, clock_complement, diff_mode, sel_n;
  logic [15:0] dq_in, dq_out, dq_host, rd_word, wr_data;
  logic [1:0] strb_in, strb_out, strb_oe, strb_host, wr_be, exp_strb;
  logic dq_oe, refresh_req, ca_valid, txn_active, rd_take;
  logic wr_valid, wr_ready, wr_overflow, drain_en;
  logic [47:0] ca_word;
  logic [31:0] seed = 32'h00000056;
  logic [31:0] rv;
  logic [17:0] words [32];
  logic [47:0] caq[$];
  logic [15:0] rq[$];
  logic [17:0] wq[$];
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;
  int drops = 0;
  int exp_drops = 0;

  // ==========================================================
  // Wire levels: whoever enables drives, else the host's pattern
  assign dq_in = dq_oe ? dq_out : dq_host;
  assign strb_in = (strb_oe & strb_out) | (~strb_oe & strb_host);

  psram_link_port psram_link_port_inst (
    .sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk),
    .clock_complement(clock_complement), .diff_mode(diff_mode),
    .sel_n(sel_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .strobe_mask_lines_in(strb_in), .strobe_mask_lines_out(strb_out),
    .strobe_mask_lines_oe(strb_oe), .refresh_req(refresh_req),
    .ca_word(ca_word), .ca_valid(ca_valid), .txn_active(txn_active),
    .rd_word(rd_word), .rd_take(rd_take), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_data(wr_data), .wr_be(wr_be),
    .wr_overflow(wr_overflow)
  );

  host_link_model host_link_model_inst (
    .sys_clk(sys_clk), .link_clk(link_clk),
    .clock_complement(clock_complement), .diff_mode(diff_mode),
    .sel_n(sel_n), .dq_host(dq_host), .strb_host(strb_host),
    .strb_wire(strb_in)
  );

  // ==========================================================
  // Clock and helpers
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [47:0] seen, input logic [47:0] exp,
    input string what);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what,
        seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================
  // Supply side: next read word ready, drain stalls at random
  always @(negedge sys_clk)
  begin
    rv = rnd();
    rd_word <= (rq.size() != 0) ? rq[0] : 16'h0000;
    wr_ready <= drain_en & rv[0];
  end

  // ==========================================================
  // Watcher: oldest note against each result as it appears
  always @(posedge sys_clk)
  begin
    cycles++;
    if (ca_valid === 1'b1)
      check(ca_word, caq.size() != 0 ? caq.pop_front() : 48'hx,
        "ca");
    if (rd_take === 1'b1)
    begin
      exp_strb = ~exp_strb;
      check(48'(dq_out), rq.size() != 0 ? 48'(rq.pop_front()) : 48'hx,
        "read word");
      check(48'({dq_oe, strb_oe, strb_out}), 48'({3'h7, exp_strb}),
        "read strobe");
    end
    if (wr_valid === 1'b1 && wr_ready === 1'b1)
      check(48'({wr_be, wr_data}), wq.size() != 0 ? 48'(wq.pop_front())
        : 48'hx, "write word");
    if (wr_overflow === 1'b1)
      drops++;
    if (cycles == 30000)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      complete_run();
    end
  end

  // ==========================================================
  // One transaction with notes of every expected result
  task automatic txn(input logic rd, input int n, input int slow);
    logic [47:0] ca;
    logic [1:0] lat;
    logic [1:0] exp_lat;
    logic [31:0] r;
    // Settled FIFO keeps the latency expectation free of races
    for (int i = 0; i < 200 && drain_en && wq.size() != 0; i++)
      @(negedge sys_clk);
    r = rnd();
    ca = {rd, r[14:0], rnd()};
    exp_lat = {2{refresh_req | (wq.size() != 0)}};
    for (int i = 0; i < 32; i++)
    begin
      r = rnd();
      words[i] = r[17:0];
      if (i < n && rd)
        rq.push_back(r[15:0]);
      else if (i < n && r[17:16] != 2'h3 && wq.size() < 16)
        wq.push_back({~r[17:16], r[15:0]});
      else if (i < n && r[17:16] != 2'h3)
        exp_drops++;
    end
    exp_strb = 2'h0;
    caq.push_back(ca);
    host_link_model_inst.run(ca, r[7:0], n, words, slow, lat);
    check(48'(lat), 48'(exp_lat), "latency flag");
    check(48'({txn_active, dq_oe, strb_oe}), 48'h0, "idle");
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    diff_mode = 1'b0;
    refresh_req = 1'b0;
    drain_en = 1'b1;
    repeat (20) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    // Single-ended, plain then with a stalling clock
    txn(1'b1, 8, 0);
    txn(1'b0, 8, 0);
    txn(1'b1, 6, 3);
    txn(1'b0, 6, 5);
    // Refresh wanted: doubled latency
    refresh_req = 1'b1;
    txn(1'b1, 4, 0);
    txn(1'b0, 4, 0);
    refresh_req = 1'b0;
    // Differential clock
    diff_mode = 1'b1;
    repeat (8) @(negedge sys_clk);
    txn(1'b1, 8, 0);
    txn(1'b0, 8, 2);
    diff_mode = 1'b0;
    // Drain stops early so no late pop races the fill notes
    drain_en = 1'b0;
    repeat (8) @(negedge sys_clk);
    // Fill until refused; pending words force extra latency
    txn(1'b0, 32, 0);
    check(48'(drops), 48'(exp_drops), "dropped words");
    txn(1'b1, 4, 0);
    drain_en = 1'b1;
    for (int i = 0; i < 500 && wq.size() != 0; i++)
      @(negedge sys_clk);
    repeat (4) @(negedge sys_clk);
    check(48'(wr_valid), 48'h0, "drained");
    // Reset in mid-read floats the lines, then standby again
    fork
      txn(1'b1, 16, 0);
      begin
        for (int i = 0; i < 2000 && dq_oe !== 1'b1; i++)
          @(negedge sys_clk);
        repeat (12) @(negedge sys_clk);
        rst_n = 1'b0;
        @(negedge sys_clk);
        check(48'({dq_oe, strb_oe, txn_active}), 48'h0, "in reset");
      end
    join
    rq.delete();
    rst_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    txn(1'b1, 4, 0);
    txn(1'b0, 4, 0);
    complete_run();
  end
endmodule
